// ===== common/nsx_pkg.sv
// Shared constants and types for the nibble-exchange / exclusive-OR execute block
package nsx_pkg;
	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int DIR_COUNT = 3;

	// ----------------------------------------
	// Opcode fields
	// ----------------------------------------
	localparam logic [5:0] OPC_NIBBLE_EXCHANGE = 6'h0e;
	localparam logic [5:0] OPC_XOR_REGISTER = 6'h06;
	localparam logic [5:0] OPC_XOR_IMMEDIATE = 6'h3a;
	localparam logic [10:0] OPC_PIN_DIRECTION = 11'h00c;
	localparam int OPC_HI_POS = 8;
	localparam int OPC_DIR_POS = 3;
	localparam int DEST_POS = 7;
	localparam logic [2:0] DIR_SEL_LO = 3'h5;
	localparam logic [2:0] DIR_SEL_HI = 3'h7;

	// ----------------------------------------
	// Data-memory placement of the direction registers
	// ----------------------------------------
	localparam logic [6:0] DIR_ADDR_LO = 7'h45;
	localparam logic [6:0] DIR_ADDR_HI = 7'h47;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET = 8'hff;
	localparam logic [13:0] INSTR_RESET = 14'h0000;

	typedef enum logic [1:0]
	{
		NSX_ALU_PASS = 2'b00,
		NSX_ALU_SWAP = 2'b01,
		NSX_ALU_XOR_REG = 2'b10,
		NSX_ALU_XOR_IMM = 2'b11
	} nsx_alu_op_t;

	typedef enum logic [1:0]
	{
		NSX_ST_IDLE = 2'b00,
		NSX_ST_EXEC = 2'b01
	} nsx_state_t;
endpackage

// ===== common/nsx_alu_if.sv
// Carrier between the execute sequencer and its result unit
`timescale 1ns/1ps
interface nsx_alu_if;
	import nsx_pkg::*;
	nsx_alu_op_t op;
	logic [7:0] acc;
	logic [7:0] operand;
	logic [7:0] imm;
	logic [7:0] result;
	logic zero;

	modport core
	(
		output op,
		output acc,
		output operand,
		output imm,
		input result,
		input zero
	);

	modport alu
	(
		input op,
		input acc,
		input operand,
		input imm,
		output result,
		output zero
	);
endinterface

// ===== hw/nsx_alu.sv
// Result unit: nibble exchange, exclusive OR and accumulator pass-through
`timescale 1ns/1ps
module nsx_alu
	import nsx_pkg::*;
(
	nsx_alu_if.alu bus
);
	wire [7:0] swapped = {bus.operand[3:0], bus.operand[7:4]};
	wire [7:0] xor_reg = bus.acc ^ bus.operand;
	wire [7:0] xor_imm = bus.acc ^ bus.imm;

	assign bus.result = (bus.op == NSX_ALU_SWAP) ? swapped :
		(bus.op == NSX_ALU_XOR_REG) ? xor_reg :
		(bus.op == NSX_ALU_XOR_IMM) ? xor_imm : bus.acc;
	assign bus.zero = (bus.result == 8'h00);
endmodule

// ===== hw/nsx_exec.sv
// Decode and execute of nibble exchange, direction load and exclusive-OR instructions
`timescale 1ns/1ps
// Overview of operation
// - Nibble exchange result takes operand low nibble high and high nibble low.
// - Nibble exchange with destination bit zero writes accumulator, source untouched.
// - Nibble exchange with destination bit one writes back to addressed register.
// - Direction load copies accumulator into direction register selected 5 to 7.
// - Direction registers also readable and writable through data-memory addressing.
// - Immediate exclusive OR combines accumulator with literal into accumulator.
// - Immediate exclusive OR sets zero flag on zero result, clears otherwise.
// - Register exclusive OR combines accumulator with register at 7-bit address.
// - Register exclusive OR with destination bit zero stores to accumulator.
// - Register exclusive OR with destination bit one stores back to register.
// - Register exclusive OR updates only zero flag from its result.
module nsx_exec
	import nsx_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic instr_valid,
	input wire logic [13:0] instr_word,
	input wire logic [7:0] mem_rdata,
	input wire logic dm_req,
	input wire logic dm_we,
	input wire logic [6:0] dm_addr,
	input wire logic [7:0] dm_wdata,
	output logic instr_ready,
	output logic exec_done,
	output logic [7:0] acc_out,
	output logic zero_flag,
	output logic [6:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	output logic [23:0] dir_out,
	output logic [7:0] dm_rdata
);
	// ----------------------------------------
	// State and held instruction
	// ----------------------------------------
	nsx_state_t state;
	nsx_state_t next_state;
	logic [13:0] instr;
	logic [DIR_COUNT-1:0][7:0] dir_reg;

	nsx_alu_if alu_bus ();

	nsx_alu u_alu
	(
		.bus(alu_bus)
	);

	// ----------------------------------------
	// Decode of the incoming word, used at the accept edge
	// ----------------------------------------
	wire take = instr_valid && instr_ready;
	wire [5:0] in_hi = instr_word[13:OPC_HI_POS];
	wire [6:0] in_f = instr_word[6:0];
	wire in_needs_mem = (in_hi == OPC_NIBBLE_EXCHANGE) || (in_hi == OPC_XOR_REGISTER);
	wire in_f_hit = (in_f >= DIR_ADDR_LO) && (in_f <= DIR_ADDR_HI);

	// ----------------------------------------
	// Decode of the held instruction, used at the execute edge
	// ----------------------------------------
	wire exec = (state == NSX_ST_EXEC);
	wire [5:0] op_hi = instr[13:OPC_HI_POS];
	wire op_swap = (op_hi == OPC_NIBBLE_EXCHANGE);
	wire op_xor_register_op = (op_hi == OPC_XOR_REGISTER);
	wire op_xor_immediate_op = (op_hi == OPC_XOR_IMMEDIATE);
	wire [2:0] dir_sel = instr[2:0];
	wire sel_ok = (dir_sel >= DIR_SEL_LO) && (dir_sel <= DIR_SEL_HI);
	// Selectors outside 5..7 name no register, so the word acts as a no-op
	wire op_dirld = (instr[13:OPC_DIR_POS] == OPC_PIN_DIRECTION) && sel_ok;
	wire dest = instr[DEST_POS];
	wire [6:0] f_addr = instr[6:0];
	wire f_hit = (f_addr >= DIR_ADDR_LO) && (f_addr <= DIR_ADDR_HI);
	wire [6:0] f_diff = f_addr - DIR_ADDR_LO;
	wire [1:0] f_idx = f_diff[1:0];
	wire [2:0] sel_diff = dir_sel - DIR_SEL_LO;
	wire [1:0] sel_idx = sel_diff[1:0];
	// Direction registers live here, so reads of them bypass data memory
	wire [7:0] operand = f_hit ? dir_reg[f_idx] : mem_rdata;

	wire to_acc = ((op_swap || op_xor_register_op) && !dest) || op_xor_immediate_op;
	wire to_reg = (op_swap || op_xor_register_op) && dest;
	wire set_zero = op_xor_register_op || op_xor_immediate_op;
	wire reg_to_mem = exec && to_reg && !f_hit;

	assign alu_bus.op = op_swap ? NSX_ALU_SWAP :
		op_xor_register_op ? NSX_ALU_XOR_REG :
		op_xor_immediate_op ? NSX_ALU_XOR_IMM : NSX_ALU_PASS;
	assign alu_bus.acc = acc_out;
	assign alu_bus.operand = operand;
	assign alu_bus.imm = instr[7:0];

	wire [6:0] dm_diff = dm_addr - DIR_ADDR_LO;
	wire [1:0] dm_idx = dm_diff[1:0];
	wire dm_hit = dm_req && (dm_addr >= DIR_ADDR_LO) && (dm_addr <= DIR_ADDR_HI);

	// ----------------------------------------
	// Sequencer: accept edge, then execute edge
	// ----------------------------------------
	always_comb
	begin
		next_state = state;
		case (state)
			NSX_ST_IDLE:
			begin
				if (take)
					next_state = NSX_ST_EXEC;
			end
			NSX_ST_EXEC:
			begin
				next_state = NSX_ST_IDLE;
			end
			default:
			begin
				next_state = NSX_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			state <= NSX_ST_IDLE;
			instr_ready <= 1'b0;
			exec_done <= 1'b0;
			instr <= INSTR_RESET;
		end
		else
		begin
			state <= next_state;
			instr_ready <= (next_state == NSX_ST_IDLE);
			exec_done <= exec;
			if (take)
				instr <= instr_word;
		end
	end

	// ----------------------------------------
	// Data-memory read and write-back
	// ----------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			mem_addr <= 7'h00;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_wdata <= 8'h00;
		end
		else
		begin
			mem_rd <= take && in_needs_mem && !in_f_hit;
			mem_wr <= reg_to_mem;
			if (take)
				mem_addr <= in_f;
			if (reg_to_mem)
				mem_wdata <= alu_bus.result;
		end
	end

	// ----------------------------------------
	// Accumulator and zero flag
	// ----------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			acc_out <= ACC_RESET;
			zero_flag <= 1'b0;
		end
		else
		begin
			if (exec && to_acc)
				acc_out <= alu_bus.result;
			if (exec && set_zero)
				zero_flag <= alu_bus.zero;
		end
	end

	// ----------------------------------------
	// Direction registers
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < DIR_COUNT; gi++)
		begin : g_dir
			// An instruction write beats a same-cycle data-memory port write
			wire ins_load = exec && op_dirld && (sel_idx == 2'(gi));
			wire ins_back = exec && to_reg && f_hit && (f_idx == 2'(gi));
			wire port_wr = dm_hit && dm_we && (dm_idx == 2'(gi));
			wire [7:0] next_dir = ins_load ? acc_out :
				ins_back ? alu_bus.result :
				port_wr ? dm_wdata : dir_reg[gi];

			always_ff @(posedge sys_clk)
			begin
				if (reset)
					dir_reg[gi] <= DIR_RESET;
				else
					dir_reg[gi] <= next_dir;
			end
		end
	endgenerate

	assign dir_out = dir_reg;

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			dm_rdata <= 8'h00;
		else if (dm_hit && !dm_we)
			dm_rdata <= dir_reg[dm_idx];
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence accept_s;
		instr_valid && instr_ready;
	endsequence

	sequence finish_s;
		exec ##1 (exec_done && instr_ready);
	endsequence

	one_cycle_a: assert property (accept_s |=> finish_s)
		else $error("instruction did not finish in one cycle");

	swap_to_reg_a: assert property (exec && op_swap && dest && !f_hit |=>
		mem_wr && mem_wdata == {$past(operand[3:0]), $past(operand[7:4])})
		else $error("nibble exchange write-back wrong");

	swap_to_acc_a: assert property (exec && op_swap && !dest |=>
		!mem_wr && acc_out == {$past(operand[3:0]), $past(operand[7:4])})
		else $error("nibble exchange to accumulator wrong");

	dir_load_a: assert property (exec && op_dirld |=>
		dir_reg[$past(sel_idx)] == $past(acc_out))
		else $error("direction load wrong");

	dir_read_a: assert property (dm_hit && !dm_we |=>
		dm_rdata == $past(dir_reg[dm_idx]))
		else $error("direction register read wrong");

	xor_imm_a: assert property (exec && op_xor_immediate_op |=>
		acc_out == ($past(acc_out) ^ $past(instr[7:0])) && zero_flag == (acc_out == 8'h00))
		else $error("immediate exclusive OR wrong");

	xor_reg_acc_a: assert property (exec && op_xor_register_op && !dest |=>
		acc_out == ($past(acc_out) ^ $past(operand)) && !mem_wr)
		else $error("register exclusive OR to accumulator wrong");

	xor_reg_back_a: assert property (exec && op_xor_register_op && dest && !f_hit |=>
		mem_wr && mem_wdata == ($past(acc_out) ^ $past(operand)) && $stable(acc_out))
		else $error("register exclusive OR write-back wrong");

	xor_zero_a: assert property (exec && op_xor_register_op |=>
		zero_flag == ($past(acc_out ^ operand) == 8'h00))
		else $error("register exclusive OR zero flag wrong");

	flags_kept_a: assert property (exec && (op_swap || op_dirld) |=> $stable(zero_flag))
		else $error("flag changed by exchange or direction load");

	read_issue_a: assert property (accept_s and (in_needs_mem && !in_f_hit) |=>
		mem_rd && mem_addr == $past(in_f))
		else $error("operand read not issued");
endmodule

// ===== dv/nsx_tb.sv
// Self-checking bench for the nibble-exchange / exclusive-OR execute block
`timescale 1ns/1ps
module tb
	import nsx_pkg::*;
;
	logic sys_clk, reset, instr_valid, dm_req, dm_we;
	logic instr_ready, exec_done, zero_flag, mem_rd, mem_wr;
	logic [13:0] instr_word;
	logic [7:0] mem_rdata, dm_wdata, acc_out, mem_wdata, dm_rdata, acc_m;
	logic [6:0] dm_addr, mem_addr;
	logic [23:0] dir_out, dir_m;
	int n_errors, n_compared;

	nsx_exec uut (.sys_clk, .reset, .instr_valid, .instr_word, .mem_rdata, .dm_req, .dm_we,
		.dm_addr, .dm_wdata, .instr_ready, .exec_done, .acc_out, .zero_flag, .mem_addr,
		.mem_rd, .mem_wr, .mem_wdata, .dir_out, .dm_rdata);

	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic stop_test;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Offers one word, waits for acceptance, ends at the settled cycle after execute
	task automatic exec(input logic [13:0] w, input logic [7:0] rd, input logic rd_exp);
		int i;
		i = 0;
		@(posedge sys_clk);
		instr_valid <= 1'b1;
		instr_word <= w;
		@(negedge sys_clk);
		while (instr_ready !== 1'b1 && i < 20)
		begin
			@(negedge sys_clk);
			i++;
		end
		if (i == 20)
		begin
			n_errors++;
			stop_test();
		end
		@(posedge sys_clk);
		instr_valid <= 1'b0;
		mem_rdata <= rd;
		@(negedge sys_clk);
		chk(mem_rd, rd_exp);
		if (rd_exp)
			chk(mem_addr, w[6:0]);
		chk(instr_ready, 1'b0);
		@(posedge sys_clk);
		// Stale read data must not look valid
		mem_rdata <= ~rd;
		@(negedge sys_clk);
		chk(exec_done, 1'b1);
	endtask

	task automatic set_acc(input logic [7:0] v);
		exec({OPC_XOR_IMMEDIATE, acc_m ^ v}, 8'h00, 1'b0);
		acc_m = v;
		chk(acc_out, v);
		chk(zero_flag, v == 8'h00);
	endtask

	task automatic dm_acc(input logic we, input logic [6:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		dm_req <= 1'b1;
		dm_we <= we;
		dm_addr <= a;
		dm_wdata <= d;
		@(posedge sys_clk);
		dm_req <= 1'b0;
		@(negedge sys_clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		chk(dir_out, 24'hffffff);
		chk(acc_out, 8'h00);
		chk(zero_flag, 1'b0);
		chk(instr_ready, 1'b1);
	endtask

	task automatic t_xor_imm;
		set_acc(8'hb5);
		exec({OPC_XOR_IMMEDIATE, 8'haf}, 8'h00, 1'b0);
		chk(acc_out, 8'h1a);
		chk(zero_flag, 1'b0);
		exec({OPC_XOR_IMMEDIATE, 8'h1a}, 8'h00, 1'b0);
		chk(acc_out, 8'h00);
		chk(zero_flag, 1'b1);
		acc_m = 8'h00;
	endtask

	task automatic t_swap;
		exec({OPC_NIBBLE_EXCHANGE, 1'b0, 7'h10}, 8'ha5, 1'b1);
		chk(mem_wr, 1'b0);
		chk(acc_out, 8'h5a);
		chk(zero_flag, 1'b1);
		acc_m = 8'h5a;
		exec({OPC_NIBBLE_EXCHANGE, 1'b1, 7'h10}, 8'h3c, 1'b1);
		chk(mem_wr, 1'b1);
		chk(mem_addr, 7'h10);
		chk(mem_wdata, 8'hc3);
		chk(acc_out, 8'h5a);
	endtask

	task automatic t_xor_reg;
		set_acc(8'hb5);
		exec({OPC_XOR_REGISTER, 1'b1, 7'h7f}, 8'haf, 1'b1);
		chk(mem_wr, 1'b1);
		chk(mem_wdata, 8'h1a);
		chk(acc_out, 8'hb5);
		chk(zero_flag, 1'b0);
		exec({OPC_XOR_REGISTER, 1'b0, 7'h00}, 8'hb5, 1'b1);
		chk(mem_wr, 1'b0);
		chk(acc_out, 8'h00);
		chk(zero_flag, 1'b1);
		acc_m = 8'h00;
	endtask

	task automatic t_dir;
		int s;
		logic [7:0] v;
		for (s = 4; s < 8; s++)
		begin
			v = 8'h11 * s[7:0];
			set_acc(v);
			exec({OPC_PIN_DIRECTION, s[2:0]}, 8'h00, 1'b0);
			// Selector 4 is outside the legal range and must change nothing
			if (s > 4)
				dir_m[(s - 5) * 8 +: 8] = v;
			chk(dir_out, dir_m);
		end
	endtask

	task automatic t_dm;
		dm_acc(1'b1, 7'h46, 8'h3c);
		dir_m[15:8] = 8'h3c;
		chk(dir_out, dir_m);
		dm_acc(1'b0, 7'h46, 8'h00);
		chk(dm_rdata, 8'h3c);
		dm_acc(1'b1, 7'h44, 8'hee);
		chk(dir_out, dir_m);
		dm_acc(1'b0, 7'h47, 8'h00);
		chk(dm_rdata, dir_m[23:16]);
		// Equal nibbles would hide a missing exchange, so use the 0x3c register
		exec({OPC_NIBBLE_EXCHANGE, 1'b1, 7'h46}, 8'h00, 1'b0);
		dir_m[15:8] = {dir_m[11:8], dir_m[15:12]};
		chk(dir_out, dir_m);
		chk(mem_wr, 1'b0);
		// Operand must come from the direction register, not from data memory
		exec({OPC_XOR_REGISTER, 1'b0, DIR_ADDR_LO}, 8'h00, 1'b0);
		acc_m = acc_m ^ dir_m[7:0];
		chk(acc_out, acc_m);
		chk(zero_flag, acc_m == 8'h00);
		chk(mem_wr, 1'b0);
	endtask

	initial
	begin
		n_errors = 0;
		n_compared = 0;
		reset = 1'b1;
		instr_valid = 1'b0;
		instr_word = 14'h0000;
		mem_rdata = 8'h00;
		dm_req = 1'b0;
		dm_we = 1'b0;
		dm_addr = 7'h00;
		dm_wdata = 8'h00;
		acc_m = 8'h00;
		dir_m = 24'hffffff;
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		@(negedge sys_clk);
		t_reset();
		t_xor_imm();
		t_swap();
		t_xor_reg();
		t_dir();
		t_dm();
		stop_test();
	end
endmodule
